// File: hdl/emx_alu.sv
// Purpose: Package and combinational result unit for the extended memory operations
// Assumes: One 8-bit operand from data memory, one from the accumulator
// Notes: Package holds every offset, field position and opcode, and the accumulator, flags and pointer reset values
package emx_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] EMX_OFF_CMD = 8'h00;
  localparam logic [7:0] EMX_OFF_ACC = 8'h04;
  localparam logic [7:0] EMX_OFF_FLAGS = 8'h08;
  localparam logic [7:0] EMX_OFF_MADDR = 8'h0c;
  localparam logic [7:0] EMX_OFF_MDATA = 8'h10;
  localparam logic [7:0] EMX_OFF_SEQ = 8'h14;
  // Command field positions
  localparam int EMX_CMD_OP_LSB = 0;
  localparam int EMX_CMD_BIT_LSB = 5;
  localparam int EMX_CMD_ADDR_LSB = 8;
  // Sequencer status bit positions
  localparam int EMX_SEQ_BUSY_BIT = 0;
  localparam int EMX_SEQ_SKIP_BIT = 1;
  localparam int EMX_SEQ_DUMMY_BIT = 2;
  // Reset values
  localparam logic [7:0] EMX_ACC_RST = 8'h00;
  localparam logic [5:0] EMX_FLAGS_RST = 6'h00;
  localparam logic [7:0] EMX_MADDR_RST = 8'h00;
  // Constants of the datapath
  localparam logic [7:0] EMX_ALL_ONES = 8'hff;
  localparam logic [7:0] EMX_ONE = 8'h01;
  localparam int EMX_MEM_DEPTH = 256;

  // Operation codes
  typedef enum logic [4:0] {
    EMX_OR_M = 5'h00, EMX_RL_M = 5'h01, EMX_RL_A = 5'h02, EMX_RLC_M = 5'h03,
    EMX_RLC_A = 5'h04, EMX_RR_M = 5'h05, EMX_RR_A = 5'h06, EMX_RRC_M = 5'h07,
    EMX_RRC_A = 5'h08, EMX_SBC_A = 5'h09, EMX_SBC_M = 5'h0a, EMX_SDZ_M = 5'h0b,
    EMX_SDZ_A = 5'h0c, EMX_SET_B = 5'h0d, EMX_SET_BIT = 5'h0e, EMX_SIZ_M = 5'h0f,
    EMX_SIZ_A = 5'h10, EMX_SNZ_BIT = 5'h11, EMX_SNZ_B = 5'h12, EMX_SUB_A = 5'h13,
    EMX_SUB_M = 5'h14, EMX_SWAP_M = 5'h15, EMX_SWAP_A = 5'h16
  } emx_op_t;

  // Status flags, carry in bit 0
  typedef struct packed {
    logic chained_zero_flag;
    logic signed_compare_flag;
    logic signed_wrap_flag;
    logic z;
    logic nibble_carry_flag;
    logic c;
  } emx_flags_t;

  // Command word as written by software
  typedef struct packed {
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [4:0] op;
  } emx_cmd_t;

  // Result of one operation
  typedef struct packed {
    logic [7:0] result;
    logic wr_mem;
    logic wr_acc;
    logic skip;
    emx_flags_t flags;
  } emx_alu_out_t;
endpackage

`timescale 1ns/1ps
`default_nettype none

module emx_alu
  import emx_pkg::*;
(
  // Operation select
  input wire logic [4:0] op,
  input wire logic [2:0] bit_sel,
  // Operands
  input wire logic [7:0] acc,
  input wire logic [7:0] mdat,
  input wire emx_flags_t flags_in,
  // Result
  output emx_alu_out_t alu_out
);
  // Subtract as add of inverted operand; carry in is one or the carry flag
  wire logic is_sbc = (op == EMX_SBC_A) || (op == EMX_SBC_M);
  wire logic sub_cin = is_sbc ? flags_in.c : 1'b1;
  wire logic [4:0] sub_lo = {1'b0, acc[3:0]} + {1'b0, ~mdat[3:0]} + {4'h0, sub_cin};
  wire logic [8:0] sub_full = {1'b0, acc} + {1'b0, ~mdat} + {8'h00, sub_cin};
  wire logic [7:0] sub_res = sub_full[7:0];
  wire logic sub_ov = (acc[7] ^ mdat[7]) & (acc[7] ^ sub_res[7]);
  wire logic [7:0] dec_res = mdat - EMX_ONE;
  wire logic [7:0] inc_res = mdat + EMX_ONE;
  wire logic [7:0] or_res = acc | mdat;
  wire logic [7:0] bit_mask = EMX_ONE << bit_sel;

  // Per-operation result, destination, flags and skip
  always_comb
  begin
    alu_out = '0;
    alu_out.flags = flags_in;
    unique case (op)
      EMX_OR_M:
      begin
        alu_out.result = or_res; // see RULE1
        alu_out.wr_mem = 1'b1;
        alu_out.flags.z = (or_res == 8'h00); // see RULE19
      end
      EMX_RL_M, EMX_RL_A:
      begin
        alu_out.result = {mdat[6:0], mdat[7]}; // see RULE2
        alu_out.wr_mem = (op == EMX_RL_M);
        alu_out.wr_acc = (op == EMX_RL_A);
      end
      EMX_RLC_M, EMX_RLC_A:
      begin
        alu_out.result = {mdat[6:0], flags_in.c}; // see RULE3
        alu_out.flags.c = mdat[7];
        alu_out.wr_mem = (op == EMX_RLC_M);
        alu_out.wr_acc = (op == EMX_RLC_A);
      end
      EMX_RR_M, EMX_RR_A:
      begin
        alu_out.result = {mdat[0], mdat[7:1]}; // see RULE4
        alu_out.wr_mem = (op == EMX_RR_M);
        alu_out.wr_acc = (op == EMX_RR_A);
      end
      EMX_RRC_M, EMX_RRC_A:
      begin
        alu_out.result = {flags_in.c, mdat[7:1]}; // see RULE5
        alu_out.flags.c = mdat[0];
        alu_out.wr_mem = (op == EMX_RRC_M);
        alu_out.wr_acc = (op == EMX_RRC_A);
      end
      EMX_SBC_A, EMX_SBC_M, EMX_SUB_A, EMX_SUB_M:
      begin
        alu_out.result = sub_res; // see RULE6 see RULE7
        alu_out.wr_acc = (op == EMX_SBC_A) || (op == EMX_SUB_A);
        alu_out.wr_mem = (op == EMX_SBC_M) || (op == EMX_SUB_M);
        alu_out.flags.c = sub_full[8]; // see RULE8
        alu_out.flags.nibble_carry_flag = sub_lo[4];
        alu_out.flags.signed_wrap_flag = sub_ov;
        alu_out.flags.z = (sub_res == 8'h00); // see RULE19
        alu_out.flags.signed_compare_flag = sub_res[7] ^ sub_ov;
        // Borrowing form chains zero over multi-byte work
        alu_out.flags.chained_zero_flag = (sub_res == 8'h00) & (~is_sbc | flags_in.chained_zero_flag);
      end
      EMX_SDZ_M, EMX_SDZ_A:
      begin
        alu_out.result = dec_res; // see RULE9 see RULE11
        alu_out.wr_mem = (op == EMX_SDZ_M);
        alu_out.wr_acc = (op == EMX_SDZ_A);
        alu_out.skip = (dec_res == 8'h00);
      end
      EMX_SIZ_M, EMX_SIZ_A:
      begin
        alu_out.result = inc_res; // see RULE10 see RULE11
        alu_out.wr_mem = (op == EMX_SIZ_M);
        alu_out.wr_acc = (op == EMX_SIZ_A);
        alu_out.skip = (inc_res == 8'h00);
      end
      EMX_SET_B:
      begin
        alu_out.result = EMX_ALL_ONES; // see RULE13
        alu_out.wr_mem = 1'b1;
      end
      EMX_SET_BIT:
      begin
        alu_out.result = mdat | bit_mask; // see RULE14
        alu_out.wr_mem = 1'b1;
      end
      EMX_SNZ_BIT:
      begin
        alu_out.result = mdat;
        alu_out.skip = |(mdat & bit_mask); // see RULE15
      end
      EMX_SNZ_B:
      begin
        alu_out.result = mdat; // see RULE16
        alu_out.wr_mem = 1'b1;
        alu_out.skip = (mdat != 8'h00);
      end
      EMX_SWAP_M, EMX_SWAP_A:
      begin
        alu_out.result = {mdat[3:0], mdat[7:4]}; // see RULE17
        alu_out.wr_mem = (op == EMX_SWAP_M);
        alu_out.wr_acc = (op == EMX_SWAP_A);
      end
      default:
      begin
        // Unknown code: no write, no skip
        alu_out.result = mdat;
      end
    endcase
  end
endmodule

`default_nettype wire

// File: hdl/emx_core.sv
// Purpose: Extended memory operation datapath with sequencer and APB registers
// Assumes: pclk at 50 MHz, one instruction cycle per enabled clock
// Notes: Data memory is a flat array addressed directly in full
// Function
// RULE1 - OR accumulator into byte, zero flag only
// RULE2 - Rotate left, bit 7 to bit 0
// RULE3 - Rotate left through carry, carry only
// RULE4 - Rotate right, bit 0 to bit 7
// RULE5 - Rotate right through carry, carry only
// RULE6 - Subtract with borrow, six flags updated
// RULE7 - Plain subtract, same six flags
// RULE8 - Carry clear if negative, else set
// RULE9 - Decrement byte, write back, skip on zero
// RULE10 - Increment byte, write back, skip on zero
// RULE11 - Accumulator forms leave memory untouched
// RULE12 - Taken skip costs three instruction cycles
// RULE13 - Set byte to all ones, no flags
// RULE14 - Set selected bit only, no flags
// RULE15 - Skip when selected bit is one
// RULE16 - Rewrite byte, skip when nonzero
// RULE17 - Swap nibbles to memory or accumulator
// RULE18 - Any data memory byte addressed directly
// RULE19 - Zero flag reflects 8-bit result
// RULE20 - Dummy cycle discards fetched instruction
`timescale 1ns/1ps
`default_nettype none

module emx_core
  import emx_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequencer status
  output logic busy,
  output logic discard_fetch
);
  // Sequencer states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXEC = 2'b01,
    S_FETCH = 2'b10,
    S_DUMMY = 2'b11
  } emx_state_t;

  emx_state_t state; // Current cycle of the instruction
  emx_state_t next_state; // Following cycle
  emx_cmd_t cmd; // Latched command
  logic [7:0] acc; // Accumulator
  emx_flags_t flags; // Status flags
  logic [7:0] maddr; // Software memory pointer
  logic skip_pend; // Skip decided in execute cycle
  logic last_skip; // Last instruction skipped
  logic [7:0] mem [0:EMX_MEM_DEPTH-1]; // Data memory, all sections
  emx_alu_out_t alu_out; // Datapath result

  // Bus decode
  wire logic apb_acc = psel & penable & ce;
  wire logic apb_wr = apb_acc & pwrite;
  wire logic idle = (state == S_IDLE);
  wire logic hit_cmd = (paddr == EMX_OFF_CMD);
  wire logic hit_acc = (paddr == EMX_OFF_ACC);
  wire logic hit_flags = (paddr == EMX_OFF_FLAGS);
  wire logic hit_maddr = (paddr == EMX_OFF_MADDR);
  wire logic hit_mdata = (paddr == EMX_OFF_MDATA);
  wire logic hit_seq = (paddr == EMX_OFF_SEQ);
  wire logic hit_any = hit_cmd | hit_acc | hit_flags | hit_maddr | hit_mdata | hit_seq;
  // Writes that change state are only taken while idle, except the memory pointer
  wire logic wr_cmd = apb_wr & hit_cmd & idle;
  wire logic wr_acc_bus = apb_wr & hit_acc & idle;
  wire logic wr_flags_bus = apb_wr & hit_flags & idle;
  wire logic wr_maddr = apb_wr & hit_maddr;
  wire logic wr_mdata_bus = apb_wr & hit_mdata & idle;

  // Operand read from the full address, bank free
  wire logic [7:0] mdat = mem[cmd.addr]; // see RULE18
  wire logic exec = ce & (state == S_EXEC);
  wire logic exec_wr_mem = exec & alu_out.wr_mem;
  wire logic exec_wr_acc = exec & alu_out.wr_acc;
  wire logic [7:0] seq_word = {5'h00, state == S_DUMMY, last_skip, ~idle};

  // Result unit
  emx_alu u_alu (
    .op(cmd.op),
    .bit_sel(cmd.bit_sel),
    .acc(acc),
    .mdat(mdat),
    .flags_in(flags),
    .alu_out(alu_out)
  );

  // Bus answers at once while enabled
  assign pready = ce;
  assign pslverr = psel & penable & ~hit_any;
  assign busy = ~idle;
  assign discard_fetch = (state == S_DUMMY); // see RULE20

  // Read mux
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite)
    begin
      if (hit_cmd)
        prdata = {16'h0000, cmd};
      else if (hit_acc)
        prdata = {24'h00_0000, acc};
      else if (hit_flags)
        prdata = {26'h000_0000, flags};
      else if (hit_maddr)
        prdata = {24'h00_0000, maddr};
      else if (hit_mdata)
        prdata = {24'h00_0000, mem[maddr]};
      else if (hit_seq)
        prdata = {24'h00_0000, seq_word};
    end
  end

  // Next sequencer state
  always_comb
  begin
    next_state = state;
    unique case (state)
      S_IDLE:
        if (wr_cmd)
          next_state = S_EXEC;
      S_EXEC:
        next_state = S_FETCH;
      S_FETCH:
        next_state = skip_pend ? S_DUMMY : S_IDLE; // see RULE12
      S_DUMMY:
        next_state = S_IDLE;
    endcase
  end

  // Sequencer and command latch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= S_IDLE;
      cmd <= '0;
      skip_pend <= 1'b0;
      last_skip <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
      if (wr_cmd)
        cmd <= pwdata[15:0];
      if (state == S_EXEC)
        skip_pend <= alu_out.skip; // see RULE12
      if (state == S_FETCH)
        last_skip <= skip_pend;
    end
  end

  // Accumulator and flags; dummy cycle writes nothing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc <= EMX_ACC_RST;
      flags <= EMX_FLAGS_RST;
    end
    else
    begin
      if (exec_wr_acc)
        acc <= alu_out.result; // see RULE11
      else if (wr_acc_bus)
        acc <= pwdata[7:0];
      if (exec)
        flags <= alu_out.flags;
      else if (wr_flags_bus)
        flags <= pwdata[5:0];
    end
  end

  // Memory pointer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      maddr <= EMX_MADDR_RST;
    else if (wr_maddr)
      maddr <= pwdata[7:0];
  end

  // Data memory write port
  always_ff @(posedge pclk)
  begin
    if (exec_wr_mem)
      mem[cmd.addr] <= alu_out.result; // see RULE18
    else if (wr_mdata_bus)
      mem[maddr] <= pwdata[7:0];
  end

  // Checks
  a_or_zero_only: assert property (@(posedge pclk) disable iff (!presetn) // see RULE1
    exec && cmd.op == EMX_OR_M |=> mem[$past(cmd.addr)] == ($past(acc) | $past(mdat))
      && flags.z == (($past(acc) | $past(mdat)) == 8'h00) && flags.c == $past(flags.c))
    else $error("OR into memory result or flags wrong");

  a_rotl_acc: assert property (@(posedge pclk) disable iff (!presetn) // see RULE2
    exec && cmd.op == EMX_RL_A |=> acc == {$past(mdat[6:0]), $past(mdat[7])} && flags == $past(flags))
    else $error("Rotate left to accumulator wrong");

  a_rlc_carry: assert property (@(posedge pclk) disable iff (!presetn) // see RULE3
    exec && cmd.op == EMX_RLC_A |=> flags.c == $past(mdat[7]) && acc[0] == $past(flags.c))
    else $error("Rotate left through carry wrong");

  a_rrc_mem: assert property (@(posedge pclk) disable iff (!presetn) // see RULE5
    exec && cmd.op == EMX_RRC_M |=> flags.c == $past(mdat[0])
      && mem[$past(cmd.addr)] == {$past(flags.c), $past(mdat[7:1])} && acc == $past(acc))
    else $error("Rotate right through carry wrong");

  a_sub_carry: assert property (@(posedge pclk) disable iff (!presetn) // see RULE8
    exec && cmd.op == EMX_SUB_A |=> flags.c == ($past(acc) >= $past(mdat))
      && acc == 8'($past(acc) - $past(mdat)))
    else $error("Subtract carry or result wrong");

  a_sbc_borrow: assert property (@(posedge pclk) disable iff (!presetn) // see RULE6
    exec && cmd.op == EMX_SBC_M && !flags.c |=> mem[$past(cmd.addr)] == 8'($past(acc) - $past(mdat) - 8'h01))
    else $error("Subtract with borrow result wrong");

  a_skip_three: assert property (@(posedge pclk) disable iff (!presetn) // see RULE12
    exec && alu_out.skip ##1 ce |=> state == S_DUMMY)
    else $error("Taken skip did not insert dummy cycle");

  a_noskip_two: assert property (@(posedge pclk) disable iff (!presetn) // see RULE12
    exec && !alu_out.skip ##1 ce |=> state == S_IDLE)
    else $error("Untaken skip inserted a cycle");

  a_dummy_quiet: assert property (@(posedge pclk) disable iff (!presetn) // see RULE20
    state == S_DUMMY |=> acc == $past(acc) && flags == $past(flags))
    else $error("Dummy cycle changed state");

  a_siz_acc: assert property (@(posedge pclk) disable iff (!presetn) // see RULE11
    exec && cmd.op == EMX_SIZ_A |=> acc == 8'($past(mdat) + 8'h01)
      && mem[$past(cmd.addr)] == $past(mdat) && skip_pend == (acc == 8'h00))
    else $error("Increment to accumulator wrong");

  a_set_byte: assert property (@(posedge pclk) disable iff (!presetn) // see RULE13
    exec && cmd.op == EMX_SET_B |=> mem[$past(cmd.addr)] == 8'hff && flags == $past(flags))
    else $error("Set byte wrong");

  a_swap_acc: assert property (@(posedge pclk) disable iff (!presetn) // see RULE17
    exec && cmd.op == EMX_SWAP_A |=> acc == {$past(mdat[3:0]), $past(mdat[7:4])})
    else $error("Nibble swap to accumulator wrong");

  // Memory forms of the plain rotates and the swap leave accumulator and flags alone
  a_rotl_mem: assert property (@(posedge pclk) disable iff (!presetn) // see RULE2
    exec && cmd.op == EMX_RL_M |=> mem[$past(cmd.addr)] == {$past(mdat[6:0]), $past(mdat[7])}
      && acc == $past(acc) && flags == $past(flags))
    else $error("Rotate left to memory wrong");

  a_rotr_mem: assert property (@(posedge pclk) disable iff (!presetn) // see RULE4
    exec && cmd.op == EMX_RR_M |=> mem[$past(cmd.addr)] == {$past(mdat[0]), $past(mdat[7:1])}
      && acc == $past(acc) && flags == $past(flags))
    else $error("Rotate right to memory wrong");

  a_swap_mem: assert property (@(posedge pclk) disable iff (!presetn) // see RULE17
    exec && cmd.op == EMX_SWAP_M |=> mem[$past(cmd.addr)] == {$past(mdat[3:0]), $past(mdat[7:4])}
      && acc == $past(acc) && flags == $past(flags))
    else $error("Nibble swap to memory wrong");

  // Plain subtract into memory, zero and chained zero agree
  a_sub_mem: assert property (@(posedge pclk) disable iff (!presetn) // see RULE7
    exec && cmd.op == EMX_SUB_M |=> mem[$past(cmd.addr)] == 8'($past(acc) - $past(mdat)) && acc == $past(acc)
      && flags.z == (mem[$past(cmd.addr)] == 8'h00) && flags.chained_zero_flag == flags.z)
    else $error("Subtract to memory wrong");

  // Skip and set-bit forms: written value, skip decision except for set bit, flags kept except for the accumulator decrement
  a_sdz_mem: assert property (@(posedge pclk) disable iff (!presetn) // see RULE9
    exec && cmd.op == EMX_SDZ_M |=> mem[$past(cmd.addr)] == 8'($past(mdat) - 8'h01)
      && skip_pend == ($past(mdat) == 8'h01) && flags == $past(flags))
    else $error("Decrement and skip to memory wrong");

  a_siz_mem: assert property (@(posedge pclk) disable iff (!presetn) // see RULE10
    exec && cmd.op == EMX_SIZ_M |=> mem[$past(cmd.addr)] == 8'($past(mdat) + 8'h01)
      && skip_pend == ($past(mdat) == 8'hff) && flags == $past(flags))
    else $error("Increment and skip to memory wrong");

  a_sdz_acc: assert property (@(posedge pclk) disable iff (!presetn) // see RULE11
    exec && cmd.op == EMX_SDZ_A |=> acc == 8'($past(mdat) - 8'h01)
      && mem[$past(cmd.addr)] == $past(mdat) && skip_pend == (acc == 8'h00))
    else $error("Decrement to accumulator wrong");

  a_set_bit: assert property (@(posedge pclk) disable iff (!presetn) // see RULE14
    exec && cmd.op == EMX_SET_BIT |=> mem[$past(cmd.addr)] == ($past(mdat) | (8'h01 << $past(cmd.bit_sel)))
      && flags == $past(flags))
    else $error("Set bit wrong");

  a_bit_skip: assert property (@(posedge pclk) disable iff (!presetn) // see RULE15
    exec && cmd.op == EMX_SNZ_BIT |=> skip_pend == $past(mdat[cmd.bit_sel])
      && mem[$past(cmd.addr)] == $past(mdat) && flags == $past(flags))
    else $error("Bit test skip wrong");

  a_byte_skip: assert property (@(posedge pclk) disable iff (!presetn) // see RULE16
    exec && cmd.op == EMX_SNZ_B |=> skip_pend == ($past(mdat) != 8'h00)
      && mem[$past(cmd.addr)] == $past(mdat) && flags == $past(flags))
    else $error("Byte test skip wrong");

  // One dummy cycle only, then back to idle
  a_dummy_one: assert property (@(posedge pclk) disable iff (!presetn) // see RULE12
    state == S_DUMMY && ce |=> state == S_IDLE)
    else $error("Dummy cycle lasted too long");
endmodule

`default_nettype wire

// File: bench/emx_host_model.sv
// Purpose: APB master standing in for the host that drives the core
// Assumes: Slave answers with pready at a rising edge
// Notes: Signals change only just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module emx_host_model (
  // Clock
  input wire logic pclk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One transfer; an idle edge first keeps drivers single per step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Hold until pready is sampled high
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: bench/test_emx_core.sv
// Purpose: Self-checking bench for the extended memory datapath
// Assumes: Zero wait states while ce is high
// Notes: Expected values come from a local reference model
`timescale 1ns/1ps
`default_nettype none
module test_emx_core
  import emx_pkg::*;
;
  // Clock, reset and bus
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, busy, discard_fetch;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int busy_cnt = 0;
  int disc_cnt = 0;
  always #10 pclk = ~pclk;
  emx_core dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .discard_fetch(discard_fetch));
  emx_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Verdict and end of run
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Enabled busy and dummy cycle counts, hang guard
  always @(posedge pclk)
  begin
    cycles++;
    if (busy === 1'b1 && ce === 1'b1)
      busy_cnt++;
    if (discard_fetch === 1'b1 && ce === 1'b1)
      disc_cnt++;
    if (cycles == 5000)
    begin
      mismatches++;
      finish_test();
    end
  end
  // Compare one word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Bus wrappers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic x;
    host.xfer(1'b1, a, d, r, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic x;
    host.xfer(1'b0, a, 32'h0, r, x);
  endtask
  // Reference results of one operation
  function automatic void model(input logic [4:0] op, input logic [2:0] b, input logic [7:0] a,
    input logic [7:0] m, input emx_flags_t f, output logic [7:0] ea, output logic [7:0] em,
    output emx_flags_t ef, output logic es);
    logic [8:0] d;
    logic [4:0] n;
    logic bw;
    ea = a;
    em = m;
    ef = f;
    es = 1'b0;
    bw = (op == EMX_SBC_A || op == EMX_SBC_M) ? ~f.c : 1'b0;
    d = {1'b0, a} - {1'b0, m} - 9'(bw);
    n = {1'b0, a[3:0]} - {1'b0, m[3:0]} - 5'(bw);
    case (op)
      EMX_OR_M: em = a | m;
      EMX_RL_M: em = {m[6:0], m[7]};
      EMX_RL_A: ea = {m[6:0], m[7]};
      EMX_RLC_M: {ef.c, em} = {m, f.c};
      EMX_RLC_A: {ef.c, ea} = {m, f.c};
      EMX_RR_M: em = {m[0], m[7:1]};
      EMX_RR_A: ea = {m[0], m[7:1]};
      EMX_RRC_M: {em, ef.c} = {f.c, m};
      EMX_RRC_A: {ea, ef.c} = {f.c, m};
      EMX_SBC_A, EMX_SUB_A: ea = d[7:0];
      EMX_SBC_M, EMX_SUB_M: em = d[7:0];
      EMX_SDZ_M: em = m - 8'h01;
      EMX_SDZ_A: ea = m - 8'h01;
      EMX_SIZ_M: em = m + 8'h01;
      EMX_SIZ_A: ea = m + 8'h01;
      EMX_SET_B: em = 8'hff;
      EMX_SET_BIT: em = m | (8'h01 << b);
      EMX_SNZ_BIT: es = m[b];
      EMX_SNZ_B: es = (m != 8'h00);
      EMX_SWAP_M: em = {m[3:0], m[7:4]};
      EMX_SWAP_A: ea = {m[3:0], m[7:4]};
      default: ;
    endcase
    // Skip on a zero result of the adjusted byte
    if (op inside {EMX_SDZ_M, EMX_SIZ_M})
      es = (em == 8'h00);
    if (op inside {EMX_SDZ_A, EMX_SIZ_A})
      es = (ea == 8'h00);
    // Zero flag only for the OR form
    if (op == EMX_OR_M)
      ef.z = (em == 8'h00);
    // Six flags of the subtract forms
    if (op inside {EMX_SBC_A, EMX_SBC_M, EMX_SUB_A, EMX_SUB_M})
    begin
      ef.c = ~d[8];
      ef.nibble_carry_flag = ~n[4];
      ef.z = (d[7:0] == 8'h00);
      ef.signed_wrap_flag = (a[7] != m[7]) && (d[7] != a[7]);
      ef.signed_compare_flag = d[7] ^ ef.signed_wrap_flag;
      ef.chained_zero_flag = ef.z & ((op inside {EMX_SUB_A, EMX_SUB_M}) | f.chained_zero_flag);
    end
  endfunction
  // Load operands, launch, wait, then check every result
  task automatic run(input logic [4:0] op, input logic [2:0] b, input logic [7:0] ad,
    input logic [7:0] a, input logic [7:0] m, input logic [5:0] f, input logic poke);
    logic [31:0] s;
    logic [7:0] ea, em;
    emx_flags_t ef;
    logic es;
    int k;
    model(op, b, a, m, f, ea, em, ef, es);
    wr(EMX_OFF_ACC, {24'h0, a});
    wr(EMX_OFF_FLAGS, {26'h0, f});
    wr(EMX_OFF_MADDR, {24'h0, ad});
    wr(EMX_OFF_MDATA, {24'h0, m});
    busy_cnt = 0;
    disc_cnt = 0;
    wr(EMX_OFF_CMD, {16'h0, ad, b, op});
    // Write while busy must be ignored
    if (poke)
      wr(EMX_OFF_ACC, 32'hee);
    k = 0;
    do
    begin
      rd(EMX_OFF_SEQ, s);
      k++;
    end
    while (s[EMX_SEQ_BUSY_BIT] !== 1'b0 && k < 20);
    chk(32'(s[EMX_SEQ_SKIP_BIT]), 32'(es), "skip");
    chk(busy_cnt, es ? 3 : 2, "cycles");
    chk(disc_cnt, es ? 1 : 0, "dummy");
    rd(EMX_OFF_ACC, q);
    chk(q, {24'h0, ea}, "acc");
    rd(EMX_OFF_MDATA, q);
    chk(q, {24'h0, em}, "mem");
    rd(EMX_OFF_FLAGS, q);
    chk(q, {26'h0, ef}, "flags");
    $display("test op %h done", op);
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(EMX_OFF_ACC, q);
    chk(q, {24'h0, EMX_ACC_RST}, "acc rst");
    rd(EMX_OFF_FLAGS, q);
    chk(q, {26'h0, EMX_FLAGS_RST}, "flags rst");
    host.xfer(1'b0, 8'h18, 32'h0, q, e);
    chk(q, 32'h0, "unmapped read");
    chk(32'(e), 32'h1, "unmapped error");
    // Clock enable low stalls the bus and freezes the sequencer
    fork
      begin
        repeat (4) @(posedge pclk);
        ce <= 1'b0;
        repeat (5) @(posedge pclk);
        ce <= 1'b1;
      end
      run(EMX_SWAP_M, 3'h0, 8'h8c, 8'h00, 8'h5a, 6'h00, 1'b0);
    join
    for (int i = 0; i < 23; i++)
      run(5'(i), 3'(i), 8'(i * 11), 8'(8'h37 + i * 13), 8'(8'hc1 ^ (i * 5)), 6'(i * 3), 1'b0);
    run(EMX_SDZ_M, 3'h0, 8'hff, 8'h10, 8'h01, 6'h3f, 1'b0);
    run(EMX_SDZ_A, 3'h0, 8'h00, 8'h10, 8'h01, 6'h00, 1'b0);
    run(EMX_SIZ_M, 3'h0, 8'h80, 8'h00, 8'hff, 6'h00, 1'b1);
    run(EMX_SIZ_A, 3'h0, 8'h81, 8'h00, 8'hff, 6'h15, 1'b0);
    run(EMX_SNZ_BIT, 3'h7, 8'h82, 8'h00, 8'h80, 6'h00, 1'b0);
    run(EMX_SNZ_BIT, 3'h0, 8'h83, 8'h00, 8'hfe, 6'h00, 1'b0);
    run(EMX_SNZ_B, 3'h0, 8'h84, 8'h00, 8'h00, 6'h00, 1'b0);
    run(EMX_SUB_A, 3'h0, 8'h85, 8'h42, 8'h42, 6'h00, 1'b0);
    run(EMX_SBC_M, 3'h0, 8'h86, 8'h00, 8'h00, 6'h20, 1'b0);
    run(EMX_SBC_A, 3'h0, 8'h87, 8'h80, 8'h01, 6'h21, 1'b0);
    run(EMX_SBC_A, 3'h0, 8'h88, 8'h05, 8'h05, 6'h21, 1'b0);
    run(EMX_OR_M, 3'h0, 8'h89, 8'h00, 8'h00, 6'h00, 1'b0);
    run(EMX_RRC_A, 3'h0, 8'h8a, 8'h00, 8'h01, 6'h01, 1'b0);
    run(5'h1f, 3'h3, 8'h8b, 8'h12, 8'h34, 6'h2a, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
